// [include/aed_pkg.sv]
// Shared constants and types for the add / AND execution datapath
package aed_pkg;

   // Data and address widths
   localparam int DATA_W = 8;                  // Data path width
   localparam int BANK_W = 4;                  // Bank number width
   localparam int ADDR_W = BANK_W + DATA_W;    // Full data memory address width
   localparam int INSTR_W = 16;                // Instruction word width

   // Instruction word field positions
   localparam int DEST_BIT = 9;                // Destination select bit
   localparam int BANK_BIT = 8;                // Bank select bit (0 = access bank)
   localparam int OPC6_HI = 15;                // Six-bit opcode field, top
   localparam int OPC6_LO = 10;                // Six-bit opcode field, bottom
   localparam int OPC8_LO = 8;                 // Eight-bit opcode field, bottom

   // Opcode values
   localparam logic [7:0] OPC_ADD_LIT = 8'h0f;    // Upper byte 0000 1111
   localparam logic [7:0] OPC_AND_LIT = 8'h0b;    // Upper byte 0000 1011
   localparam logic [5:0] OPC_ADD_FILE = 6'h09;   // Top six bits 001001
   localparam logic [5:0] OPC_ADD_CARRY = 6'h08;  // Top six bits 001000
   localparam logic [5:0] OPC_AND_FILE = 6'h05;   // Top six bits 000101

   // Destination select encoding; the file register is the default
   localparam logic DEST_WORK = 1'b0;          // Result to working register
   localparam logic DEST_FILE = 1'b1;          // Result back to file register

   // Access bank layout: low half maps to bank 0, high half to top bank
   localparam logic [DATA_W-1:0] ACCESS_SPLIT_DEF = 8'h80;  // First high-half address
   localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;    // Bank of low half
   localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;   // Bank of high half

   // Reset values
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;  // Working register after reset
   localparam logic FLAG_RST = 1'b0;                // Each status flag after reset

   // Quarter phases of one instruction cycle
   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROCESS,
      PH_WRITE
   } aed_phase_t;

   // Operations carried by this datapath
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ADD_LIT,
      OP_ADD_FILE,
      OP_ADD_CARRY,
      OP_AND_LIT,
      OP_AND_FILE
   } aed_op_t;

   // Whole state of the datapath
   typedef struct packed {
      aed_phase_t              phase;     // Current quarter phase
      logic                    busy;      // Instruction in flight
      aed_op_t                 op;        // Decoded operation
      logic                    dest;      // Destination select
      logic [ADDR_W-1:0]       addr;      // Resolved data memory address
      logic [DATA_W-1:0]       operand;   // Literal or file operand
      logic [DATA_W-1:0]       result;    // Processed result
      logic                    res_neg;   // Pending negative flag
      logic                    res_ovf;   // Pending overflow flag
      logic                    res_zero;  // Pending zero flag
      logic                    res_dcar;  // Pending digit carry flag
      logic                    res_car;   // Pending carry flag
      logic [DATA_W-1:0]       work;      // Working register
      logic                    neg;       // Negative flag
      logic                    ovf;       // Overflow flag
      logic                    zero;      // Zero flag
      logic                    dcar;      // Digit carry flag
      logic                    car;       // Carry flag
      logic                    rd_en;     // Memory read strobe
      logic                    wr_en;     // Memory write strobe
      logic [DATA_W-1:0]       wr_data;   // Memory write data
      logic                    done;      // Instruction retired pulse
      logic                    unknown;   // Offered word not handled here
   } aed_state_t;

endpackage

// [sim/aed_datapath_tb_top.sv]
// Self-checking bench: driver notes expectations, monitor compares
module aed_datapath_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aed_pkg::*;

   localparam int SPLIT  = 128;    // Access bank split handed to the design
   localparam int N_RAND = 300;    // Random instructions after the directed list

   logic                sys_clk, rst, instr_valid, instr_ready, mem_rd_en, mem_wr_en;
   logic                instr_done, instr_unknown, neg_f, ovf_f, zero_f, dcar_f, car_f;
   logic [INSTR_W-1:0]  instr_word;       // Offered word
   logic [BANK_W-1:0]   bank_sel;         // Bank select contents
   logic [ADDR_W-1:0]   mem_addr;         // Resolved address
   logic [DATA_W-1:0]   mem_rd_data, mem_wr_data, work;
   logic [1:0]          quarter;          // Phase counter
   logic [DATA_W-1:0]   w_m;              // Modelled working register
   logic                n_m, v_m, z_m, d_m, c_m;   // Modelled flags
   logic [DATA_W-1:0]   shadow [2**ADDR_W];         // Modelled memory
   logic [12:0]         q_done [$];       // Expected {work, N, OV, Z, DC, C}
   logic [19:0]         q_wr [$];         // Expected {addr, data} writes
   logic [11:0]         q_rd [$];         // Expected read addresses
   int                  unk_pend, miscompares, total_checks;

   aed_datapath #(.ACCESS_SPLIT(SPLIT)) dut (
      .SYS_CLK(sys_clk), .RST(rst), .INSTR_WORD(instr_word), .INSTR_VALID(instr_valid),
      .INSTR_READY(instr_ready), .BANK_SELECT_REGISTER(bank_sel), .MEM_ADDR(mem_addr),
      .MEM_RD_EN(mem_rd_en), .MEM_RD_DATA(mem_rd_data), .MEM_WR_EN(mem_wr_en),
      .MEM_WR_DATA(mem_wr_data), .WORKING_REGISTER(work), .NEGATIVE_FLAG(neg_f),
      .OVERFLOW_FLAG(ovf_f), .ZERO_FLAG(zero_f), .DIGIT_CARRY_FLAG(dcar_f),
      .CARRY_FLAG(car_f), .QUARTER(quarter), .INSTR_DONE(instr_done),
      .INSTR_UNKNOWN(instr_unknown));

   aed_mem_model mem (
      .clk(sys_clk), .addr(mem_addr), .rd_en(mem_rd_en), .rd_data(mem_rd_data),
      .wr_en(mem_wr_en), .wr_data(mem_wr_data));

   // Free running 100 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // One comparison, counted; a mismatch is reported at once
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // Ends the run from the main sequence or the watchdog
   task automatic print_verdict();
      if (miscompares == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Offer one word at a decode quarter and note what must follow
   task automatic issue(input logic [15:0] wd, input logic [3:0] bank_select_register);
      logic [7:0]  k, op, r;
      logic [8:0]  s;
      logic [4:0]  lo;
      logic [11:0] a;
      logic        file_f, known, add_f, cin;
      k = wd[7:0];
      a = wd[BANK_BIT] ? {bank_select_register, k} : ((k < SPLIT) ? {ACCESS_LOW_BANK, k} : {ACCESS_HIGH_BANK, k});
      file_f = wd[OPC6_HI:OPC6_LO] inside {OPC_ADD_FILE, OPC_ADD_CARRY, OPC_AND_FILE};
      known = file_f || (wd[15:OPC8_LO] inside {OPC_ADD_LIT, OPC_AND_LIT});
      add_f = wd[15:OPC8_LO] == OPC_ADD_LIT
              || (wd[OPC6_HI:OPC6_LO] inside {OPC_ADD_FILE, OPC_ADD_CARRY});
      op = file_f ? shadow[a] : k;
      cin = (wd[OPC6_HI:OPC6_LO] == OPC_ADD_CARRY) ? c_m : 1'b0;
      if (!known) unk_pend++;
      else
      begin
         if (add_f)
         begin
            s = {1'b0, w_m} + {1'b0, op} + 9'(cin);
            lo = {1'b0, w_m[3:0]} + {1'b0, op[3:0]} + 5'(cin);
            r = s[7:0];
            v_m = (w_m[7] == op[7]) && (r[7] != w_m[7]);
            c_m = s[8];
            d_m = lo[4];
         end
         else r = w_m & op;
         n_m = r[7];
         z_m = (r == 8'h00);
         if (file_f) q_rd.push_back(a);
         if (file_f && wd[DEST_BIT] == DEST_FILE)
         begin
            shadow[a] = r;
            q_wr.push_back({a, r});
         end
         else w_m = r;
         q_done.push_back({w_m, n_m, v_m, z_m, d_m, c_m});
      end
      for (int i = 0; i < 4 && instr_ready !== 1'b1; i++) @(negedge sys_clk);
      instr_word = wd;
      bank_sel = bank_select_register;
      instr_valid = 1'b1;
      // Junk offered outside the decode quarter must be ignored
      repeat (3)
      begin
         @(negedge sys_clk);
         instr_word = 16'($urandom);
         bank_sel = 4'($urandom);
      end
      @(negedge sys_clk);
   endtask

   // Monitor: take the oldest note whenever a result shows
   always @(negedge sys_clk)
   begin
      if (!rst && mem_rd_en)
      begin
         check(32'(quarter), 32'h1, "read quarter");
         if (q_rd.size() == 0) check(32'h1, 32'h0, "unexpected read");
         else check(32'(mem_addr), 32'(q_rd.pop_front()), "read address");
      end
      if (!rst && mem_wr_en)
      begin
         check(32'(quarter), 32'h3, "write quarter");
         if (q_wr.size() == 0) check(32'h1, 32'h0, "unexpected write");
         else check(32'({mem_addr, mem_wr_data}), 32'(q_wr.pop_front()), "write");
      end
      if (!rst && instr_done)
      begin
         check(32'(quarter), 32'h0, "done quarter");
         if (q_done.size() == 0) check(32'h1, 32'h0, "unexpected done");
         else check(32'({work, neg_f, ovf_f, zero_f, dcar_f, car_f}),
                    32'(q_done.pop_front()), "work and flags");
      end
      if (!rst && instr_unknown)
      begin
         unk_pend--;
         check(32'(unk_pend < 0), 32'h0, "unexpected unknown flag");
      end
   end

   // Watchdog, well beyond the planned run of some 1280 cycles
   initial
   begin
      repeat (6000) @(posedge sys_clk);
      miscompares++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      logic [15:0] dir [14];
      logic [15:0] wd;
      dir = '{16'h0f10, 16'h0f15, 16'h0f7f, 16'h0f01, 16'h0f80, 16'h0bff, 16'h0b00,
              16'h247f, 16'h2480, 16'h2733, 16'h2333, 16'h1633, 16'h1580, 16'hffff};
      {instr_valid, instr_word, bank_sel} = '0;
      rst = 1'b1;
      miscompares = 0;
      total_checks = 0;
      unk_pend = 0;
      {w_m, n_m, v_m, z_m, d_m, c_m} = '0;
      for (int i = 0; i < 2**ADDR_W; i++) shadow[i] = 8'(i * 37 + 11);
      void'($urandom(32'hf4148d9c));
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      check(32'({work, neg_f, ovf_f, zero_f, dcar_f, car_f, quarter}), 32'h0, "reset state");
      // Directed: overflow, carry, zero, access split edge, both destinations
      foreach (dir[i]) issue(dir[i], 4'h3);
      // Random mix of all five forms plus foreign words
      for (int i = 0; i < N_RAND; i++)
      begin
         wd = 16'($urandom);
         case ($urandom_range(0, 5))
            0: wd[15:8] = OPC_ADD_LIT;
            1: wd[15:10] = OPC_ADD_FILE;
            2: wd[15:10] = OPC_ADD_CARRY;
            3: wd[15:8] = OPC_AND_LIT;
            4: wd[15:10] = OPC_AND_FILE;
            default: wd = wd;
         endcase
         issue(wd, 4'($urandom));
      end
      instr_valid = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(32'(q_done.size() + q_wr.size() + q_rd.size() + unk_pend), 32'h0, "missing results");
      print_verdict();
   end
endmodule // aed_datapath_tb_top

// [sim/aed_mem_model.sv]
// Banked data memory on the far side of the datapath
module aed_mem_model
(
   input  wire logic                         clk,
   input  wire logic [aed_pkg::ADDR_W-1:0]   addr,
   input  wire logic                         rd_en,
   output logic [aed_pkg::DATA_W-1:0]        rd_data,
   input  wire logic                         wr_en,
   input  wire logic [aed_pkg::DATA_W-1:0]   wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import aed_pkg::*;

   logic [DATA_W-1:0]   mem_r [2**ADDR_W];   // Whole data memory, fixed pattern at start
   logic [DATA_W-1:0]   last_r;              // Last byte read, for the idle data value

   // Preload; the bench rebuilds the same pattern in its shadow copy
   initial
   begin
      for (int i = 0; i < 2**ADDR_W; i++) mem_r[i] = 8'(i * 37 + 11);
      last_r = 8'h00;
   end

   // Writes land at the end of the write quarter
   always @(posedge clk)
   begin
      if (wr_en) mem_r[addr] <= wr_data;
      if (rd_en) last_r <= mem_r[addr];
   end

   // Same-cycle read; when idle show the inverse so stale data never looks valid
   assign rd_data = rd_en ? mem_r[addr] : ~last_r;
endmodule // aed_mem_model

// [verilog/aed_datapath.sv]
// Summary of operation
// RULE_01 - Add literal to working register
// RULE_02 - 001001 adds working register to file
// RULE_03 - 001000 adds working, carry and file
// RULE_04 - AND literal into working register
// RULE_05 - 000101 ANDs working register with file
// RULE_06 - Destination 0 writes working register only
// RULE_07 - Destination 1 writes data memory location
// RULE_08 - File register is default destination encoding
// RULE_09 - Bank bit 0 uses fixed access bank
// RULE_10 - Bank bit 1 uses bank select register
// RULE_11 - One cycle: decode, read, process, write
// RULE_12 - Adds set five flags; ANDs set two
module aed_datapath #(
   parameter int ACCESS_SPLIT = 128            // First access address of the high half
) (
   input  wire logic                          SYS_CLK,
   input  wire logic                          RST,
   input  wire logic [aed_pkg::INSTR_W-1:0]   INSTR_WORD,
   input  wire logic                          INSTR_VALID,
   output logic                               INSTR_READY,
   input  wire logic [aed_pkg::BANK_W-1:0]    BANK_SELECT_REGISTER,
   output logic [aed_pkg::ADDR_W-1:0]         MEM_ADDR,
   output logic                               MEM_RD_EN,
   input  wire logic [aed_pkg::DATA_W-1:0]    MEM_RD_DATA,
   output logic                               MEM_WR_EN,
   output logic [aed_pkg::DATA_W-1:0]         MEM_WR_DATA,
   output logic [aed_pkg::DATA_W-1:0]         WORKING_REGISTER,
   output logic                               NEGATIVE_FLAG,
   output logic                               OVERFLOW_FLAG,
   output logic                               ZERO_FLAG,
   output logic                               DIGIT_CARRY_FLAG,
   output logic                               CARRY_FLAG,
   output logic [1:0]                         QUARTER,
   output logic                               INSTR_DONE,
   output logic                               INSTR_UNKNOWN
);
   import aed_pkg::*;

   // Refuse a split that does not fit the eight-bit file address
   if (ACCESS_SPLIT < 0 || ACCESS_SPLIT > 256)
   begin : g_split_check
      $error("ACCESS_SPLIT must lie in 0..256");
   end

   // Low half of access bank is below this address
   localparam logic [DATA_W:0] SPLIT_W = (DATA_W+1)'(ACCESS_SPLIT);

   aed_state_t q_r;    // Registered state
   aed_state_t q_nxt;  // Next state

   // Decode helpers, valid only in the decode quarter
   aed_op_t             dec_op;     // Operation of the offered word
   logic                dec_file;   // Operation reads a file register
   logic [BANK_W-1:0]   dec_bank;   // Bank chosen for the file address
   logic [DATA_W-1:0]   dec_f;      // File address field

   // Instruction word decode
   always_comb
   begin
      dec_f = INSTR_WORD[DATA_W-1:0];
      if (INSTR_WORD[INSTR_W-1:OPC8_LO] == OPC_ADD_LIT)
      begin
         dec_op = OP_ADD_LIT;                                   // [RULE_01]
      end
      else if (INSTR_WORD[INSTR_W-1:OPC8_LO] == OPC_AND_LIT)
      begin
         dec_op = OP_AND_LIT;                                   // [RULE_04]
      end
      else if (INSTR_WORD[OPC6_HI:OPC6_LO] == OPC_ADD_FILE)
      begin
         dec_op = OP_ADD_FILE;                                  // [RULE_02]
      end
      else if (INSTR_WORD[OPC6_HI:OPC6_LO] == OPC_ADD_CARRY)
      begin
         dec_op = OP_ADD_CARRY;                                 // [RULE_03]
      end
      else if (INSTR_WORD[OPC6_HI:OPC6_LO] == OPC_AND_FILE)
      begin
         dec_op = OP_AND_FILE;                                  // [RULE_05]
      end
      else
      begin
         dec_op = OP_NONE;    // Belongs to another unit of the core
      end
      dec_file = (dec_op == OP_ADD_FILE) || (dec_op == OP_ADD_CARRY) ||
                 (dec_op == OP_AND_FILE);
      // Bank bit chooses between access bank and bank select register
      if (INSTR_WORD[BANK_BIT])
      begin
         dec_bank = BANK_SELECT_REGISTER;                       // [RULE_10]
      end
      else if ({1'b0, dec_f} < SPLIT_W)
      begin
         dec_bank = ACCESS_LOW_BANK;                            // [RULE_09]
      end
      else
      begin
         dec_bank = ACCESS_HIGH_BANK;                           // [RULE_09]
      end
   end

   // Quarter sequencer and datapath next state
   always_comb
   begin
      logic [DATA_W:0]   sum;     // Nine-bit sum, top bit is carry
      logic [4:0]        nib;     // Low nibble sum, top bit is digit carry
      logic [DATA_W-1:0] cin;     // Carry in, zero extended
      sum = '0;
      nib = '0;
      cin = '0;
      q_nxt = q_r;
      q_nxt.rd_en = 1'b0;
      q_nxt.wr_en = 1'b0;
      q_nxt.done = 1'b0;
      q_nxt.unknown = 1'b0;
      case (q_r.phase)
         // Decode quarter: free-running, so each instruction takes four clocks
         PH_DECODE:
         begin
            q_nxt.phase = PH_READ;                              // [RULE_11]
            q_nxt.busy = INSTR_VALID && (dec_op != OP_NONE);
            q_nxt.op = INSTR_VALID ? dec_op : OP_NONE;
            q_nxt.unknown = INSTR_VALID && (dec_op == OP_NONE);
            // Literal forms never touch memory, so they target the working register
            q_nxt.dest = dec_file ? INSTR_WORD[DEST_BIT] : DEST_WORK;  // [RULE_08]
            q_nxt.addr = {dec_bank, dec_f};
            q_nxt.operand = dec_f;
            q_nxt.rd_en = INSTR_VALID && dec_file;
         end
         // Read quarter: file operand arrives in the same cycle as the strobe
         PH_READ:
         begin
            q_nxt.phase = PH_PROCESS;                           // [RULE_11]
            if (q_r.busy && q_r.rd_en)
            begin
               q_nxt.operand = MEM_RD_DATA;
            end
         end
         // Process quarter: arithmetic and flag preparation
         PH_PROCESS:
         begin
            q_nxt.phase = PH_WRITE;                             // [RULE_11]
            cin = {{(DATA_W-1){1'b0}}, (q_r.op == OP_ADD_CARRY) & q_r.car};  // [RULE_03]
            sum = {1'b0, q_r.work} + {1'b0, q_r.operand} + {1'b0, cin};
            nib = {1'b0, q_r.work[3:0]} + {1'b0, q_r.operand[3:0]} + {4'h0, cin[0]};
            // Flags that an AND leaves alone keep their values
            q_nxt.res_ovf = q_r.ovf;
            q_nxt.res_car = q_r.car;
            q_nxt.res_dcar = q_r.dcar;
            if ((q_r.op == OP_AND_LIT) || (q_r.op == OP_AND_FILE))
            begin
               q_nxt.result = q_r.work & q_r.operand;           // [RULE_04] [RULE_05]
            end
            else
            begin
               q_nxt.result = sum[DATA_W-1:0];                  // [RULE_01] [RULE_02]
               q_nxt.res_car = sum[DATA_W];                     // [RULE_12]
               q_nxt.res_dcar = nib[4];                         // [RULE_12]
               q_nxt.res_ovf = (q_r.work[7] == q_r.operand[7]) &&
                               (sum[7] != q_r.work[7]);         // [RULE_12]
            end
            q_nxt.res_neg = q_nxt.result[DATA_W-1];             // [RULE_12]
            q_nxt.res_zero = (q_nxt.result == '0);              // [RULE_12]
            // Write strobe and data are set up so they stand for the write quarter
            q_nxt.wr_en = q_r.busy && (q_r.dest == DEST_FILE);  // [RULE_07]
            q_nxt.wr_data = q_nxt.result;
         end
         // Write quarter: commit destination and flags together
         PH_WRITE:
         begin
            q_nxt.phase = PH_DECODE;                            // [RULE_11]
            if (q_r.busy)
            begin
               if (q_r.dest == DEST_WORK)
               begin
                  q_nxt.work = q_r.result;                      // [RULE_06]
               end
               q_nxt.neg = q_r.res_neg;                         // [RULE_12]
               q_nxt.ovf = q_r.res_ovf;
               q_nxt.zero = q_r.res_zero;                       // [RULE_12]
               q_nxt.dcar = q_r.res_dcar;
               q_nxt.car = q_r.res_car;
               q_nxt.done = 1'b1;
            end
            q_nxt.busy = 1'b0;
         end
         default:
         begin
            q_nxt.phase = PH_DECODE;   // Unreachable with a two-bit phase
         end
      endcase
   end

   // State register
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         q_r <= '0;
         q_r.phase <= PH_DECODE;
         q_r.op <= OP_NONE;
         q_r.dest <= DEST_FILE;
         q_r.work <= WORK_RST;
         q_r.neg <= FLAG_RST;
         q_r.ovf <= FLAG_RST;
         q_r.zero <= FLAG_RST;
         q_r.dcar <= FLAG_RST;
         q_r.car <= FLAG_RST;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // Outputs; only the ready handshake is combinational
   assign INSTR_READY = (q_r.phase == PH_DECODE);
   assign MEM_ADDR = q_r.addr;
   assign MEM_RD_EN = q_r.rd_en;
   assign MEM_WR_EN = q_r.wr_en;
   assign MEM_WR_DATA = q_r.wr_data;
   assign WORKING_REGISTER = q_r.work;
   assign NEGATIVE_FLAG = q_r.neg;
   assign OVERFLOW_FLAG = q_r.ovf;
   assign ZERO_FLAG = q_r.zero;
   assign DIGIT_CARRY_FLAG = q_r.dcar;
   assign CARRY_FLAG = q_r.car;
   assign QUARTER = q_r.phase;
   assign INSTR_DONE = q_r.done;
   assign INSTR_UNKNOWN = q_r.unknown;

   // Accept event used by the checks below
   logic take;   // Word taken in the decode quarter
   assign take = INSTR_READY && INSTR_VALID;

   property p_add_lit;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:8] == OPC_ADD_LIT) |-> ##4
         WORKING_REGISTER == 8'($past(WORKING_REGISTER, 4) + $past(INSTR_WORD[7:0], 4));
   endproperty
   a_add_lit : assert property (p_add_lit)  // [RULE_01]
      else $error("literal add gave wrong working register");

   property p_and_lit;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:8] == OPC_AND_LIT) |-> ##4
         WORKING_REGISTER == ($past(WORKING_REGISTER, 4) & $past(INSTR_WORD[7:0], 4));
   endproperty
   a_and_lit : assert property (p_and_lit)  // [RULE_04]
      else $error("literal AND gave wrong working register");

   property p_add_file;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:10] == OPC_ADD_FILE) && INSTR_WORD[9] |-> ##3
         MEM_WR_EN && (MEM_WR_DATA == 8'($past(MEM_RD_DATA, 2) + WORKING_REGISTER));
   endproperty
   a_add_file : assert property (p_add_file)  // [RULE_02]
      else $error("file add wrote wrong sum");

   property p_add_carry;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:10] == OPC_ADD_CARRY) && !INSTR_WORD[9] |-> ##4
         WORKING_REGISTER == 8'($past(WORKING_REGISTER, 4) + $past(MEM_RD_DATA, 3)
                                + {7'h00, $past(CARRY_FLAG, 4)});
   endproperty
   a_add_carry : assert property (p_add_carry)  // [RULE_03]
      else $error("add with carry gave wrong result");

   property p_and_file;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:10] == OPC_AND_FILE) && INSTR_WORD[9] |-> ##3
         MEM_WR_EN && (MEM_WR_DATA == ($past(MEM_RD_DATA, 2) & WORKING_REGISTER));
   endproperty
   a_and_file : assert property (p_and_file)  // [RULE_05]
      else $error("file AND wrote wrong value");

   property p_dest_work;
      @(posedge SYS_CLK) disable iff (RST)
      take && (INSTR_WORD[15:12] != 4'h0) && !INSTR_WORD[9] |-> !MEM_WR_EN [*5];
   endproperty
   a_dest_work : assert property (p_dest_work)  // [RULE_06]
      else $error("write strobe with working register destination");

   property p_dest_file;
      @(posedge SYS_CLK) disable iff (RST)
      take && dec_file && INSTR_WORD[9] |-> ##4
         $stable(WORKING_REGISTER) && !MEM_WR_EN;
   endproperty
   a_dest_file : assert property (p_dest_file)  // [RULE_07]
      else $error("file destination disturbed working register");

   property p_access_bank;
      @(posedge SYS_CLK) disable iff (RST)
      take && (dec_op != OP_NONE) && !INSTR_WORD[8] |-> ##1
         MEM_ADDR == {(({1'b0, $past(INSTR_WORD[7:0])} < SPLIT_W) ? ACCESS_LOW_BANK
                       : ACCESS_HIGH_BANK), $past(INSTR_WORD[7:0])};
   endproperty
   a_access_bank : assert property (p_access_bank)  // [RULE_09]
      else $error("access bank address wrong");

   property p_banked;
      @(posedge SYS_CLK) disable iff (RST)
      take && (dec_op != OP_NONE) && INSTR_WORD[8] |-> ##1
         MEM_ADDR == {$past(BANK_SELECT_REGISTER), $past(INSTR_WORD[7:0])};
   endproperty
   a_banked : assert property (p_banked)  // [RULE_10]
      else $error("banked address wrong");

   property p_quarters;
      @(posedge SYS_CLK) disable iff (RST)
      take && (dec_op != OP_NONE) |-> ##1 (QUARTER == 2'd1) ##1 (QUARTER == 2'd2)
         ##1 (QUARTER == 2'd3) && !INSTR_DONE ##1 (QUARTER == 2'd0) && INSTR_DONE;
   endproperty
   a_quarters : assert property (p_quarters)  // [RULE_11]
      else $error("quarter sequence broken");

   property p_and_flags;
      @(posedge SYS_CLK) disable iff (RST)
      take && ((dec_op == OP_AND_LIT) || (dec_op == OP_AND_FILE)) |-> ##4
         (CARRY_FLAG == $past(CARRY_FLAG, 4)) && (OVERFLOW_FLAG == $past(OVERFLOW_FLAG, 4))
         && (DIGIT_CARRY_FLAG == $past(DIGIT_CARRY_FLAG, 4))
         && (($past(INSTR_WORD[9], 4) && ($past(INSTR_WORD[15:8], 4) != OPC_AND_LIT))
             ? ((ZERO_FLAG == ($past(MEM_WR_DATA) == 8'h00))
                && (NEGATIVE_FLAG == $past(MEM_WR_DATA[7])))
             : ((ZERO_FLAG == (WORKING_REGISTER == 8'h00))
                && (NEGATIVE_FLAG == WORKING_REGISTER[7])));
   endproperty
   a_and_flags : assert property (p_and_flags)  // [RULE_12]
      else $error("AND changed an arithmetic flag");

endmodule // aed_datapath
